// File: hw/rsw_word_mem.sv
// Sixteen-word store for the data words of a continuous write
`default_nettype none
module rsw_word_mem (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic [3:0]  rd_addr,
    output logic      [15:0] rd_data
);
    typedef struct packed {
        logic [15:0][15:0] words;
        logic [15:0]       q;
    } rsw_mem_st_t;

    rsw_mem_st_t st;
    rsw_mem_st_t next_st;

    always_comb
    begin
        next_st = st;
        if (wr_en)
        begin
            next_st.words[wr_addr] = wr_data;
        end
        next_st.q = st.words[rd_addr];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rd_data = st.q;
endmodule
`default_nettype wire

// File: hw/rsw_write_handler.sv
// RTU slave handler for single-word and continuous parameter writes
// Function
// - Single-word write carries one data word applied to the addressed parameter.
// - Successful single-word write is answered by echoing the request byte for byte.
// - Continuous write carries at most sixteen words, count set by word count.
// - Continuous write words go to consecutive addresses from the start address.
// - Continuous answer echoes address, command, start, count, then fresh CRC.
// - Frames are bounded by idle gaps of at least 3.5 characters.
// - Addresses travel high byte first; each byte may take any value.
// - Address high byte is the parameter group, low byte the index.
// - Factory group 99 is refused for reads and writes; a continuous write is refused only if it starts in group 99.
// - Run-locked parameters refused while running; read-only ones always refused.
// - Top address bit set means write RAM copy only, no nonvolatile store.
// - Top-bit alias address is invalid for reads.
// - CRC starts all ones, byte XOR then eight reflected shifts with a001.
// - Frames whose CRC does not check are dropped as transmission errors.
`default_nettype none
module rsw_write_handler #(
    parameter int GAP_CYCLES = rsw_pkg::GAP_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  own_addr,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_valid,
    output logic      [7:0]  tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic      [15:0] param_addr,
    output logic      [15:0] param_data,
    output logic             param_wr,
    output logic             param_ram_only,
    input  wire logic        param_read_only,
    input  wire logic        param_run_locked,
    input  wire logic        motor_running,
    output logic             crc_err,
    output logic             read_refused
);
    typedef struct packed {
        rsw_pkg::rsw_state_t        state;
        logic [rsw_pkg::GAP_W-1:0]  gap;
        logic [5:0]                 cnt;
        logic [15:0]                crc;
        logic [7:0][7:0]            hdr;
        logic [7:0]                 hold;
        logic [4:0]                 k;
        logic [4:0]                 nw;
        logic                       phase;
        logic [15:0]                base;
        logic [15:0]                param_addr;
        logic [15:0]                wr_data;
        logic                       wr_valid;
        logic                       ram_only;
        logic                       tx_valid;
        logic [7:0]                 tx_data;
        logic [2:0]                 t;
        logic [15:0]                crc_tx;
        logic                       crc_err;
        logic                       read_refused;
    } rsw_st_t;

    rsw_st_t     st;
    rsw_st_t     next_st;
    logic        mem_we;
    logic [3:0]  mem_waddr;
    logic [15:0] mem_wdata;
    logic [3:0]  mem_raddr;
    logic [15:0] mem_rd;
    logic [5:0]  didx;
    logic [15:0] qty;
    logic        frame_end;
    logic        factory;
    logic        is_one;
    logic        wr_ok;
    logic        locked;
    logic [15:0] nc;
    logic [2:0]  tn;

    rsw_word_mem u_mem (
        .clk     (clk),
        .reset   (reset),
        .wr_en   (mem_we),
        .wr_addr (mem_waddr),
        .wr_data (mem_wdata),
        .rd_addr (mem_raddr),
        .rd_data (mem_rd)
    );

    assign qty       = {st.hdr[rsw_pkg::HDR_QHI], st.hdr[rsw_pkg::HDR_QLO]};
    assign didx      = st.cnt - rsw_pkg::CNT_DATA;
    assign is_one    = st.hdr[rsw_pkg::HDR_CMD] == rsw_pkg::CMD_WR_ONE;
    // A frame ends only after a full idle gap; bytes arriving earlier extend it
    assign frame_end = (st.state == rsw_pkg::S_RX) && !rx_valid && (st.cnt != '0)
                     && (st.gap == rsw_pkg::GAP_W'(GAP_CYCLES - 1));
    assign factory   = st.hdr[rsw_pkg::HDR_AHI][6:0] == rsw_pkg::GROUP_FACTORY;
    assign locked    = param_read_only || (param_run_locked && motor_running);
    always_comb
    begin
        wr_ok = 1'b0;
        if (is_one)
        begin
            wr_ok = st.cnt == rsw_pkg::CNT_WR_ONE;
        end
        else if (st.hdr[rsw_pkg::HDR_CMD] == rsw_pkg::CMD_WR_MANY)
        begin
            wr_ok = (qty != '0) && (qty <= rsw_pkg::MAX_WORDS)
                  && ({8'h00, st.hdr[rsw_pkg::HDR_BC]} == {qty[14:0], 1'b0})
                  && ({3'b000, st.cnt} == rsw_pkg::CNT_WR_FIXED
                                          + {1'b0, st.hdr[rsw_pkg::HDR_BC]});
        end
        wr_ok = wr_ok && !factory;
    end

    always_comb
    begin
        next_st              = st;
        mem_we               = 1'b0;
        mem_waddr            = didx[4:1];
        mem_wdata            = {st.hold, rx_byte};
        mem_raddr            = st.k[3:0];
        nc                   = st.crc_tx;
        tn                   = st.t + 3'h1;
        next_st.wr_valid     = 1'b0;
        next_st.crc_err      = 1'b0;
        next_st.read_refused = 1'b0;
        if (rx_valid)
        begin
            next_st.gap = '0;
        end
        else if (st.gap != rsw_pkg::GAP_W'(GAP_CYCLES - 1))
        begin
            next_st.gap = st.gap + rsw_pkg::GAP_W'(1);
        end
        unique case (st.state)
            rsw_pkg::S_RX:
            begin
                if (rx_valid)
                begin
                    if (st.cnt < rsw_pkg::CNT_HDR)
                    begin
                        next_st.hdr[st.cnt[2:0]] = rx_byte;
                    end
                    // Data bytes pair high first into words of the store
                    if (st.cnt >= rsw_pkg::CNT_DATA && didx < rsw_pkg::DIDX_LIMIT)
                    begin
                        if (!didx[0])
                        begin
                            next_st.hold = rx_byte;
                        end
                        else
                        begin
                            mem_we = 1'b1;
                        end
                    end
                    next_st.crc = rsw_pkg::rsw_crc_step(st.crc, rx_byte);
                    if (st.cnt != '1)
                    begin
                        next_st.cnt = st.cnt + 6'h01;
                    end
                end
                else if (frame_end)
                begin
                    next_st.cnt = '0;
                    next_st.crc = rsw_pkg::CRC_INIT;
                    // Running CRC over a frame that includes its own CRC field ends at zero
                    if (st.crc != '0)
                    begin
                        next_st.crc_err = 1'b1;
                    end
                    else if (st.hdr[rsw_pkg::HDR_ADDR] == own_addr)
                    begin
                        if (st.hdr[rsw_pkg::HDR_CMD] == rsw_pkg::CMD_READ)
                        begin
                            next_st.read_refused = factory
                                || st.hdr[rsw_pkg::HDR_AHI][rsw_pkg::ALIAS_BIT];
                        end
                        else if (wr_ok)
                        begin
                            next_st.state      = rsw_pkg::S_CHECK;
                            next_st.k          = '0;
                            next_st.base       = {1'b0, st.hdr[rsw_pkg::HDR_AHI][6:0],
                                                  st.hdr[rsw_pkg::HDR_ALO]};
                            next_st.param_addr = next_st.base;
                            next_st.ram_only   =
                                st.hdr[rsw_pkg::HDR_AHI][rsw_pkg::ALIAS_BIT];
                            next_st.nw         = is_one ? 5'h01 : qty[4:0];
                        end
                    end
                end
            end
            rsw_pkg::S_CHECK:
            begin
                // Every target is checked before any word is written, so a frame is all or none
                if (locked)
                begin
                    next_st.state = rsw_pkg::S_RX;
                end
                else if (st.k == st.nw - 5'h01)
                begin
                    next_st.state = rsw_pkg::S_WRITE;
                    next_st.k     = '0;
                    next_st.phase = 1'b0;
                end
                else
                begin
                    next_st.k          = st.k + 5'h01;
                    next_st.param_addr = st.param_addr + 16'h0001;
                end
            end
            rsw_pkg::S_WRITE:
            begin
                if (!st.phase)
                begin
                    next_st.phase      = 1'b1;
                    next_st.param_addr = st.base + {11'h000, st.k};
                end
                else
                begin
                    next_st.phase    = 1'b0;
                    next_st.wr_valid = 1'b1;
                    next_st.wr_data  = is_one ? {st.hdr[rsw_pkg::HDR_QHI],
                                                 st.hdr[rsw_pkg::HDR_QLO]} : mem_rd;
                    if (st.k == st.nw - 5'h01)
                    begin
                        next_st.state    = rsw_pkg::S_TX;
                        next_st.t        = '0;
                        next_st.tx_valid = 1'b1;
                        next_st.tx_data  = st.hdr[rsw_pkg::HDR_ADDR];
                        next_st.crc_tx   = rsw_pkg::CRC_INIT;
                    end
                    else
                    begin
                        next_st.k = st.k + 5'h01;
                    end
                end
            end
            rsw_pkg::S_TX:
            begin
                if (tx_ready)
                begin
                    if (st.t < rsw_pkg::TX_ECHO)
                    begin
                        nc = rsw_pkg::rsw_crc_step(st.crc_tx, st.tx_data);
                    end
                    next_st.crc_tx = nc;
                    if (st.t == rsw_pkg::TX_LAST)
                    begin
                        next_st.tx_valid = 1'b0;
                        next_st.state    = rsw_pkg::S_RX;
                    end
                    else
                    begin
                        next_st.t = tn;
                        if (tn < rsw_pkg::TX_ECHO || is_one)
                        begin
                            next_st.tx_data = st.hdr[tn];
                        end
                        else
                        begin
                            next_st.tx_data = (tn == rsw_pkg::TX_ECHO) ? nc[7:0]
                                                                       : nc[15:8];
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st       <= '0;
            st.crc   <= rsw_pkg::CRC_INIT;
            st.state <= rsw_pkg::S_RX;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign tx_data        = st.tx_data;
    assign tx_valid       = st.tx_valid;
    assign param_addr     = st.param_addr;
    assign param_data     = st.wr_data;
    assign param_wr       = st.wr_valid;
    assign param_ram_only = st.ram_only;
    assign crc_err        = st.crc_err;
    assign read_refused   = st.read_refused;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_word_limit: assert property (
        st.state == rsw_pkg::S_WRITE |-> st.nw <= rsw_pkg::MAX_WORDS)
        else $error("more than sixteen words in a write");
    a_factory_block: assert property (
        param_wr |-> param_addr[14:8] != rsw_pkg::GROUP_FACTORY)
        else $error("write reached the factory group");
    a_lock_refuse: assert property (
        st.state == rsw_pkg::S_CHECK && locked |=> st.state == rsw_pkg::S_RX ##1 !param_wr)
        else $error("locked parameter not refused");
    a_ram_alias: assert property (
        param_wr |-> param_ram_only == st.hdr[rsw_pkg::HDR_AHI][rsw_pkg::ALIAS_BIT])
        else $error("RAM-only flag does not follow the address top bit");
    a_consec_addr: assert property (
        param_wr ##2 param_wr |-> param_addr == $past(param_addr, 2) + 16'h0001)
        else $error("write addresses not consecutive");
    a_echo_bytes: assert property (tx_valid && is_one |-> tx_data == st.hdr[st.t])
        else $error("single-word answer is not an echo");
    a_resp_len: assert property (
        tx_valid && tx_ready && st.t == rsw_pkg::TX_LAST |=> !tx_valid)
        else $error("answer longer than eight bytes");
    a_crc_drop: assert property (
        frame_end && st.crc != '0 |=> crc_err && st.state == rsw_pkg::S_RX)
        else $error("bad CRC frame not dropped");
    a_foreign_quiet: assert property (
        frame_end && st.hdr[rsw_pkg::HDR_ADDR] != own_addr |=> st.state == rsw_pkg::S_RX)
        else $error("frame for another slave was handled");
    a_count_check: assert property (
        frame_end && !is_one && !wr_ok |=> st.state == rsw_pkg::S_RX)
        else $error("malformed continuous write accepted");
    a_gap_wait: assert property (
        $rose(st.state == rsw_pkg::S_CHECK) |-> $past(st.gap) == rsw_pkg::GAP_W'(GAP_CYCLES - 1))
        else $error("frame taken before the idle gap");

    c_single_write: cover property (param_wr && is_one);
    c_multi_write:  cover property (param_wr ##2 param_wr);
    c_refused_lock: cover property (st.state == rsw_pkg::S_CHECK && locked);
    c_read_refused: cover property (read_refused);
endmodule
`default_nettype wire

// File: include/rsw_pkg.sv
// Constants, types and the CRC step shared by the RTU write handler
`default_nettype none
package rsw_pkg;
    // Command codes
    localparam logic [7:0]  CMD_READ      = 8'h03;
    localparam logic [7:0]  CMD_WR_ONE    = 8'h06;
    localparam logic [7:0]  CMD_WR_MANY   = 8'h10;
    // Word limit of one continuous write and the factory group number
    localparam logic [15:0] MAX_WORDS     = 16'h0010;
    localparam logic [6:0]  GROUP_FACTORY = 7'h63;
    // Byte positions and frame lengths
    localparam logic [5:0]  CNT_HDR       = 6'h08;
    localparam logic [5:0]  CNT_DATA      = 6'h07;
    localparam logic [5:0]  CNT_WR_ONE    = 6'h08;
    localparam logic [8:0]  CNT_WR_FIXED  = 9'h009;
    localparam logic [5:0]  DIDX_LIMIT    = 6'h20;
    localparam logic [2:0]  TX_ECHO       = 3'h6;
    localparam logic [2:0]  TX_LAST       = 3'h7;
    localparam logic [2:0]  HDR_ADDR      = 3'h0;
    localparam logic [2:0]  HDR_CMD       = 3'h1;
    localparam logic [2:0]  HDR_AHI       = 3'h2;
    localparam logic [2:0]  HDR_ALO       = 3'h3;
    localparam logic [2:0]  HDR_QHI       = 3'h4;
    localparam logic [2:0]  HDR_QLO       = 3'h5;
    localparam logic [2:0]  HDR_BC        = 3'h6;
    localparam int          ALIAS_BIT     = 7;
    // CRC
    localparam logic [15:0] CRC_INIT      = 16'hffff;
    localparam logic [15:0] CRC_POLY      = 16'ha001;
    // Idle gap: 3.5 characters of 11 bits at the line rate, rounded up
    localparam longint      GAP_TENTHS    = 35;
    localparam longint      CHAR_BITS     = 11;
    localparam longint      CLK_HZ        = 20000000;
    localparam longint      BAUD          = 9600;
    localparam longint      GAP_CYC_L     =
        (GAP_TENTHS * CHAR_BITS * CLK_HZ + 10 * BAUD - 1) / (10 * BAUD);
    localparam int          GAP_CYCLES    = int'(GAP_CYC_L);
    localparam int          GAP_W         = 20;

    typedef enum logic [1:0] {
        S_RX    = 2'b00,
        S_CHECK = 2'b01,
        S_WRITE = 2'b11,
        S_TX    = 2'b10
    } rsw_state_t;

    function automatic logic [15:0] rsw_crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
endpackage
`default_nettype wire

// File: testbench/rsw_master_model.sv
// Line master model: sends request frames and takes response bytes
`default_nettype none
module rsw_master_model (
    input  wire logic       clk,
    output logic      [7:0] rx_byte,
    output logic            rx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] resp[$];
    int         stall = 0;
    int         wait_n = 0;

    initial
    begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end

    function automatic logic [15:0] crc16(input logic [7:0] f[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (f[i])
        begin
            c = c ^ {8'h00, f[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        return c;
    endfunction

    // Bytes go out in the order given; CRC is expected already appended
    task automatic send(input logic [7:0] f[$]);
        foreach (f[i])
        begin
            @(negedge clk);
            rx_byte = f[i];
            rx_valid = 1'b1;
            @(negedge clk);
            rx_valid = 1'b0;
            // Stale byte must not pass for valid data
            rx_byte = ~f[i];
        end
    endtask

    // Stall lets a slow master hold the response off for a few cycles
    always @(negedge clk)
    begin
        if (tx_ready || !tx_valid)
        begin
            tx_ready <= 1'b0;
            wait_n <= 0;
        end
        else if (wait_n >= stall)
            tx_ready <= 1'b1;
        else
            wait_n <= wait_n + 1;
    end

    always @(posedge clk)
        if (tx_valid && tx_ready)
            resp.push_back(tx_data);
endmodule
`default_nettype wire

// File: testbench/rsw_write_handler_bench.sv
// Self-checking bench for the RTU write handler
`default_nettype none
module rsw_write_handler_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int GAP = 20;
    logic        clk;
    logic        reset;
    logic [7:0]  own_addr;
    logic [7:0]  rx_byte;
    logic        rx_valid;
    logic [7:0]  tx_data;
    logic        tx_valid;
    logic        tx_ready;
    logic [15:0] param_addr;
    logic [15:0] param_data;
    logic        param_wr;
    logic        param_ram_only;
    logic        param_read_only = 1'b0;
    logic        param_run_locked = 1'b0;
    logic        motor_running;
    logic        crc_err;
    logic        read_refused;
    logic [32:0] wlog[$];
    logic [7:0]  sent[$];
    int          n_fail = 0;
    int          checked = 0;
    int          cycles = 0;
    int          n_crc = 0;
    int          n_rref = 0;

    rsw_write_handler #(.GAP_CYCLES(GAP)) dut (
        .clk(clk), .reset(reset), .own_addr(own_addr), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .param_addr(param_addr), .param_data(param_data), .param_wr(param_wr),
        .param_ram_only(param_ram_only), .param_read_only(param_read_only),
        .param_run_locked(param_run_locked), .motor_running(motor_running),
        .crc_err(crc_err), .read_refused(read_refused)
    );

    rsw_master_model m (
        .clk(clk), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Attribute table: 0009 read-only, 000a locked while running
    always @(negedge clk)
    begin
        param_read_only <= (param_addr == 16'h0009);
        param_run_locked <= (param_addr == 16'h000a);
    end

    always @(posedge clk)
    begin
        if (param_wr)
            wlog.push_back({param_ram_only, param_addr, param_data});
        if (crc_err)
            n_crc++;
        if (read_refused)
            n_rref++;
        cycles++;
        if (cycles == 30000)
        begin
            n_fail++;
            finish_test();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("Counts: %0d compared, %0d mismatched", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Sends a frame with its CRC (spoiled when bad) and waits out the answer
    task automatic run(input logic [7:0] f[$], input bit bad);
        logic [15:0] c;
        logic        early;
        c = m.crc16(f) ^ {15'h0000, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        sent = f;
        m.resp.delete();
        wlog.delete();
        m.send(f);
        early = 1'b0;
        repeat (GAP - 1)
        begin
            @(negedge clk);
            early = early | tx_valid;
        end
        check(early, 1'b0);
        for (int i = 0; i < 200 && m.resp.size() < 8; i++)
            @(negedge clk);
        repeat (GAP) @(negedge clk);
    endtask

    task automatic cmp_resp(input logic [7:0] e[$]);
        check(m.resp.size(), e.size());
        foreach (e[i])
            check(m.resp[i], e[i]);
    endtask

    task automatic cmp_writes(input logic [15:0] base, input int n, input logic [15:0] d0,
                              input logic ram);
        check(wlog.size(), n);
        foreach (wlog[i])
            check(wlog[i], {ram, base + 16'(i), d0 + 16'(i)});
    endtask

    task automatic cmp_none;
        check(m.resp.size(), 0);
        check(wlog.size(), 0);
    endtask

    task automatic t_single;
        run({8'h02, 8'h06, 8'h00, 8'h04, 8'h13, 8'h88}, 0);
        cmp_resp(sent);
        cmp_writes(16'h0004, 1, 16'h1388, 1'b0);
        $display("single write test done");
    endtask

    task automatic t_multi;
        logic [7:0]  f[$];
        logic [7:0]  e[$];
        logic [15:0] c;
        f = {8'h02, 8'h10, 8'h0a, 8'h01, 8'h00, 8'h10, 8'h20};
        e = f[0:5];
        for (int i = 0; i < 16; i++)
            f = {f, 8'h12, 8'hf0 + 8'(i)};
        c = m.crc16(e);
        e = {e, c[7:0], c[15:8]};
        m.stall = 3;
        run(f, 0);
        m.stall = 0;
        cmp_resp(e);
        cmp_writes(16'h0a01, 16, 16'h12f0, 1'b0);
        $display("continuous write test done");
    endtask

    task automatic t_alias;
        run({8'h02, 8'h06, 8'h80, 8'h07, 8'h00, 8'haa}, 0);
        cmp_resp(sent);
        cmp_writes(16'h0007, 1, 16'h00aa, 1'b1);
        $display("ram alias test done");
    endtask

    task automatic t_reject;
        logic [7:0] f[$];
        int         n0;
        run({8'h05, 8'h06, 8'h00, 8'h04, 8'h00, 8'h01}, 0);
        cmp_none();
        run({8'h02, 8'h06, 8'h63, 8'h05, 8'h00, 8'h01}, 0);
        cmp_none();
        run({8'h02, 8'h06, 8'h00, 8'h09, 8'h00, 8'h01}, 0);
        cmp_none();
        // Locked word in the middle must stop the whole frame
        run({8'h02, 8'h10, 8'h00, 8'h08, 8'h00, 8'h03, 8'h06,
             8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h03}, 0);
        cmp_none();
        run({8'h02, 8'h10, 8'h00, 8'h04, 8'h00, 8'h02, 8'h03,
             8'h00, 8'h01, 8'h00, 8'h02}, 0);
        cmp_none();
        run({8'h02, 8'h10, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00}, 0);
        cmp_none();
        f = {8'h02, 8'h10, 8'h00, 8'h04, 8'h00, 8'h11, 8'h22};
        for (int i = 0; i < 17; i++)
            f = {f, 8'h00, 8'(i)};
        run(f, 0);
        cmp_none();
        n0 = n_crc;
        run({8'h02, 8'h06, 8'h00, 8'h04, 8'h00, 8'h01}, 1);
        check(n_crc - n0, 1);
        cmp_none();
        motor_running = 1'b1;
        run({8'h02, 8'h06, 8'h00, 8'h0a, 8'h00, 8'h01}, 0);
        cmp_none();
        motor_running = 1'b0;
        run({8'h02, 8'h06, 8'h00, 8'h0a, 8'h00, 8'h01}, 0);
        cmp_writes(16'h000a, 1, 16'h0001, 1'b0);
        $display("refusal test done");
    endtask

    task automatic t_read;
        int n0;
        n0 = n_rref;
        run({8'h02, 8'h03, 8'h63, 8'h00, 8'h00, 8'h01}, 0);
        run({8'h02, 8'h03, 8'h80, 8'h04, 8'h00, 8'h01}, 0);
        check(n_rref - n0, 2);
        run({8'h02, 8'h03, 8'h00, 8'h04, 8'h00, 8'h01}, 0);
        check(n_rref - n0, 2);
        cmp_none();
        $display("read refusal test done");
    endtask

    initial
    begin
        own_addr = 8'h02;
        motor_running = 1'b0;
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        t_single();
        t_multi();
        t_alias();
        t_reject();
        t_read();
        finish_test();
    end
endmodule
`default_nettype wire
